/* File: verilog/l4c_top.sv */
`timescale 1ns/100ps
`include "l4c_regs.svh"

// How it works
// - A write to the clear address while the engine is idle zeroes all sixteen operation bits.
// - Each written byte is loaded and then shifted in eight steps.
// - After the eighth step the shifter idles and holds its value.
// - Bit 0 of the result register reads 0 for a good group, 1 for error.
// - Writes to the two value ports load the operation register directly while the engine is idle.
// - Reads of the two value ports return the live operation register.
// - Saving, processing another group and reloading allows interleaving.
// - The upper port carries operation bits b7 to b0, reset zero.
// - The lower port carries operation bits b15 to b8, reset zero.
module l4c_top #(
  parameter int          ADDR_W = 12,
  parameter logic [15:0] POLY   = `L4C_POLY_DEFAULT
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              RESETN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);
  import l4c_pkg::*;

  localparam int GAP_CYC = `L4C_BYTE_GAP_CYC;

  // Buffer plus eight steps must drain well inside one byte gap
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : g_bad_addr
    $error("ADDR_W must be 8 to 32");
  end
  if (GAP_CYC < 12)
  begin : g_bad_gap
    $error("byte gap too short for the shifter");
  end

  logic        rst_meta_ff;
  logic        rst_n_ff;
  logic        rst_n;

  // Reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end
  assign rst_n = rst_n_ff;

  logic [ADDR_W-3:0] reg_idx;
  logic        hit_clear;
  logic        hit_data;
  logic        hit_result;
  logic        hit_upper;
  logic        hit_lower;
  logic        hit_any;
  logic        setup;
  logic        access;
  logic        stall;
  logic        bad;
  logic        fire_ok;
  logic        engine_idle;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        sh_in_ready;
  l4c_byte_t   buf_out_data;
  l4c_crc_t    crc;
  logic        busy;
  logic        wr_clear;
  logic        wr_upper;
  logic        wr_lower;
  logic        crc_err;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [7:0]  ld_seen_ff;
  logic [7:0]  nxt_ld_seen;

  assign reg_idx = PADDR[ADDR_W-1:2];
  assign setup   = PSEL && !PENABLE;
  assign access  = PSEL && PENABLE;

  // Address decode
  always_comb
  begin
    hit_clear  = 1'b0;
    hit_data   = 1'b0;
    hit_result = 1'b0;
    hit_upper  = 1'b0;
    hit_lower  = 1'b0;
    if (PADDR[1:0] != 2'h0)
      hit_clear = 1'b0;
    else if (reg_idx == `L4C_IDX_CLEAR)
      hit_clear = 1'b1;
    else if (reg_idx == `L4C_IDX_DATA)
      hit_data = 1'b1;
    else if (reg_idx == `L4C_IDX_RESULT)
      hit_result = 1'b1;
    else if (reg_idx == `L4C_IDX_CRC_UPPER)
      hit_upper = 1'b1;
    else if (reg_idx == `L4C_IDX_CRC_LOWER)
      hit_lower = 1'b1;
  end
  assign hit_any = hit_clear || hit_data || hit_result || hit_upper || hit_lower;

  // Direct loads are refused until queued bytes are done, keeping write order
  assign engine_idle = !busy && !buf_out_valid;

  // faster writers are held off, not dropped
  assign stall = access && PWRITE && hit_data && !buf_in_ready;
  // Refused rather than stalled: a busy engine never freezes the bus on a direct access
  assign bad   = !hit_any || (PWRITE && hit_result)
              || (PWRITE && (hit_clear || hit_upper || hit_lower) && !engine_idle);

  assign PREADY  = !stall;
  assign PSLVERR = access && !stall && bad;
  assign fire_ok = access && !stall && !bad;

  assign buf_in_valid = access && PWRITE && hit_data;
  assign wr_clear     = fire_ok && PWRITE && hit_clear;
  assign wr_upper     = fire_ok && PWRITE && hit_upper;
  assign wr_lower     = fire_ok && PWRITE && hit_lower;

  l4c_buf2 #(
    .WIDTH     (8)
  ) u_buf (
    .clk       (CLK_SYS),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (PWDATA[7:0]),
    .out_valid (buf_out_valid),
    .out_ready (sh_in_ready),
    .out_data  (buf_out_data)
  );

  l4c_shifter #(
    .POLY      (POLY)
  ) u_shift (
    .clk       (CLK_SYS),
    .rst_n     (rst_n),
    .in_valid  (buf_out_valid),
    .in_ready  (sh_in_ready),
    .in_data   (buf_out_data),
    .clr       (wr_clear),
    .ld_upper  (wr_upper),
    .ld_lower  (wr_lower),
    .ld_data   (PWDATA[7:0]),
    .crc       (crc),
    .busy      (busy)
  );

  assign crc_err = |crc;

  // Read data captured in the setup cycle
  always_comb
  begin
    nxt_prdata = prdata_ff;
    if (setup && !PWRITE)
    begin
      nxt_prdata = 32'h0000_0000;
      if (hit_result)
        nxt_prdata[`L4C_RESULT_BIT] = crc_err;
      else if (hit_upper)
        nxt_prdata[7:0] = crc[7:0];
      else if (hit_lower)
        nxt_prdata[7:0] = crc[15:8];
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      prdata_ff <= 32'h0000_0000;
    else
      prdata_ff <= nxt_prdata;
  end
  assign PRDATA = prdata_ff;

  // Last byte taken on the upper port, kept for the read-back check only
  always_comb
  begin
    nxt_ld_seen = ld_seen_ff;
    if (wr_upper)
      nxt_ld_seen = PWDATA[7:0];
  end

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      ld_seen_ff <= 8'h00;
    else
      ld_seen_ff <= nxt_ld_seen;
  end

  AST_CLEAR_ZERO: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    wr_clear |=> (crc == 16'h0000) && !busy)
    else $error("clear did not zero the operation register");

  AST_RESULT_BIT: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (access && !PWRITE && hit_result && $past(setup))
      |-> PRDATA == {31'h0000_0000, $past(crc_err)})
    else $error("result bit does not match the remainder");

  AST_LOAD_UPPER: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    wr_upper |=> crc[7:0] == $past(PWDATA[7:0]) && $stable(crc[15:8]))
    else $error("upper port load wrong");

  AST_LOAD_LOWER: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    wr_lower |=> crc[15:8] == $past(PWDATA[7:0]) && $stable(crc[7:0]))
    else $error("lower port load wrong");

  AST_READ_LIVE: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (access && !PWRITE && hit_lower && $past(setup))
      |-> PRDATA == {24'h00_0000, $past(crc[15:8])})
    else $error("lower port read not the live value");

  AST_RELOAD_ROUNDTRIP: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (wr_upper ##[2:3] (access && !PWRITE && hit_upper && $past(setup) && !busy))
      |-> PRDATA[7:0] == ld_seen_ff)
    else $error("reloaded value not read back");

  AST_RESET_IDLE: assert property (
    @(posedge CLK_SYS)
    $rose(rst_n) |-> (crc == 16'h0000) && !busy && !buf_out_valid)
    else $error("reset did not leave the block clear and idle");

  AST_NO_DROP: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (buf_in_valid && !buf_in_ready) |-> !PREADY ##1 buf_out_valid)
    else $error("byte write completed while the buffer was full");

  // Worst case: eight steps plus the idle cycle that pops the queue
  AST_STALL_BOUNDED: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    stall |-> ##[1:10] !stall)
    else $error("data write held off too long");

  AST_BYTE_QUEUED: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (buf_in_valid && buf_in_ready) |=> buf_out_valid)
    else $error("accepted byte did not reach the queue");

  AST_REFUSED_INERT: assert property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (PSLVERR && engine_idle) |=> $stable(crc))
    else $error("refused access changed the operation register");

  COV_BYTE_DONE: cover property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    $fell(busy) && !buf_out_valid && (crc == 16'h0000));

  COV_STALL: cover property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    stall ##1 !stall);

  COV_CLEAR_REFUSED: cover property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    PSLVERR && PWRITE && hit_clear);

  COV_INTERLEAVE: cover property (
    @(posedge CLK_SYS) disable iff (!rst_n)
    (access && !PWRITE && hit_upper) ##[1:300] wr_clear ##[1:300] wr_upper);

endmodule : l4c_top

/* File: verilog/l4c_regs.svh */
`ifndef L4C_REGS_SVH
`define L4C_REGS_SVH

// Register indices; the byte address is four times the index
`define L4C_IDX_CLEAR      10'h028
`define L4C_IDX_DATA       10'h029
`define L4C_IDX_RESULT     10'h02a
`define L4C_IDX_CRC_UPPER  10'h02b
`define L4C_IDX_CRC_LOWER  10'h02c

// Field positions and reset values
`define L4C_RESULT_BIT     0
`define L4C_CRC_RESET      16'h0000
`define L4C_POLY_DEFAULT   16'h1021
`define L4C_SHIFT_STEPS    4'h8

// Timing: least spacing of host byte writes
`define L4C_BYTE_GAP_NS    4500
`define L4C_CLK_NS         40
`define L4C_BYTE_GAP_CYC   ((`L4C_BYTE_GAP_NS + `L4C_CLK_NS - 1) / `L4C_CLK_NS)

`endif

/* File: verilog/l4c_pkg.sv */
package l4c_pkg;

  typedef logic [7:0]  l4c_byte_t;
  typedef logic [15:0] l4c_crc_t;

  typedef enum logic {SH_IDLE, SH_RUN} l4c_shift_e;

endpackage : l4c_pkg

/* File: verilog/l4c_buf2.sv */
`timescale 1ns/100ps

module l4c_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic             wptr_ff;
  logic             nxt_wptr;
  logic             rptr_ff;
  logic             nxt_rptr;
  logic [1:0]       count_ff;
  logic [1:0]       nxt_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  // Head entry is picked from the two registers by the read pointer
  assign out_data  = mem_ff[rptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    nxt_mem   = mem_ff;
    nxt_wptr  = wptr_ff;
    nxt_rptr  = rptr_ff;
    nxt_count = count_ff;
    if (push)
    begin
      nxt_mem[wptr_ff] = in_data;
      nxt_wptr         = !wptr_ff;
    end
    if (pop)
      nxt_rptr = !rptr_ff;
    if (push && !pop)
      nxt_count = count_ff + 2'h1;
    else if (pop && !push)
      nxt_count = count_ff - 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wptr_ff   <= 1'b0;
      rptr_ff   <= 1'b0;
      count_ff  <= 2'h0;
    end
    else
    begin
      mem_ff   <= nxt_mem;
      wptr_ff  <= nxt_wptr;
      rptr_ff  <= nxt_rptr;
      count_ff <= nxt_count;
    end
  end

endmodule : l4c_buf2

/* File: verilog/l4c_shifter.sv */
`timescale 1ns/100ps
`include "l4c_regs.svh"

module l4c_shifter #(
  parameter logic [15:0] POLY = `L4C_POLY_DEFAULT
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Byte stream
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire l4c_pkg::l4c_byte_t in_data,
  // Direct access to the operation register
  input  wire logic              clr,
  input  wire logic              ld_upper,
  input  wire logic              ld_lower,
  input  wire l4c_pkg::l4c_byte_t ld_data,
  // State
  output l4c_pkg::l4c_crc_t      crc,
  output logic                   busy
);
  import l4c_pkg::*;

  l4c_shift_e state_ff;
  l4c_shift_e nxt_state;
  l4c_crc_t   crc_ff;
  l4c_crc_t   nxt_crc;
  l4c_byte_t  byte_ff;
  l4c_byte_t  nxt_byte;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;

  assign in_ready = (state_ff == SH_IDLE);
  assign busy     = (state_ff == SH_RUN);
  assign crc      = crc_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_crc   = crc_ff;
    nxt_byte  = byte_ff;
    nxt_step  = step_ff;
    case (state_ff)
      SH_IDLE:
      begin
        if (in_valid)
        begin
          nxt_byte  = in_data;
          nxt_step  = 3'h0;
          nxt_state = SH_RUN;
        end
        else if (clr)
          nxt_crc = `L4C_CRC_RESET;
        else
        begin
          if (ld_upper)
            nxt_crc[7:0] = ld_data;
          if (ld_lower)
            nxt_crc[15:8] = ld_data;
        end
      end
      SH_RUN:
      begin
        if (crc_ff[15] ^ byte_ff[7])
          nxt_crc = {crc_ff[14:0], 1'b0} ^ POLY;
        else
          nxt_crc = {crc_ff[14:0], 1'b0};
        nxt_byte = {byte_ff[6:0], 1'b0};
        nxt_step = step_ff + 3'h1;
        if (step_ff == 3'h7)
          nxt_state = SH_IDLE;
      end
      default:
        nxt_state = SH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= SH_IDLE;
      crc_ff   <= `L4C_CRC_RESET;
      byte_ff  <= 8'h00;
      step_ff  <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      crc_ff   <= nxt_crc;
      byte_ff  <= nxt_byte;
      step_ff  <= nxt_step;
    end
  end

  AST_EIGHT_SHIFTS: assert property (
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SH_IDLE && in_valid) |=> busy [*8] ##1 !busy)
    else $error("byte not shifted exactly eight times");

  AST_IDLE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!busy && !in_valid && !clr && !ld_upper && !ld_lower) |=> $stable(crc_ff))
    else $error("operation register moved while idle");

endmodule : l4c_shifter

/* File: tb/l4c_host.sv */
`timescale 1ns/100ps
`include "l4c_regs.svh"

module l4c_host (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Bench status
  output logic             hang
);
  int stalls = 0;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    hang    = 1'b0;
  end

  // Request held until pready is taken at a rising edge
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [1:0] lo,
                      input logic [31:0] d, output logic [31:0] r, output logic e);
    logic rdy;
    int   n;
    begin
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, lo};
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
        @(posedge clk);
        rdy = pready;
        r = prdata;
        e = pslverr;
        stalls += (rdy !== 1'b1);
        n++;
      end
      while (rdy !== 1'b1 && n < 64);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (rdy !== 1'b1)
        hang <= 1'b1;
      @(posedge clk);
    end
  endtask : xfer

  task automatic put(input logic [7:0] b, input int gap);
    logic [31:0] r;
    logic        e;
    begin
      xfer(1'b1, `L4C_IDX_DATA, 2'b00, {24'h0, b}, r, e);
      repeat (gap) @(posedge clk);
    end
  endtask : put
endmodule : l4c_host

/* File: tb/layer4_crc_engine_tb.sv */
`timescale 1ns/100ps
`include "l4c_regs.svh"

module layer4_crc_engine_tb;
  localparam int GAP = `L4C_BYTE_GAP_CYC;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, hang, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] c, s;
  int          fails      = 0;
  int          num_checks = 0;
  logic [15:0] row_init [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h1234};
  logic [7:0]  row_byte [4] = '{8'h00, 8'h01, 8'h80, 8'h12};
  logic [15:0] row_crc  [4] = '{16'h0000, 16'h1021, 16'h9188, 16'h3400};

  always #20 clk_sys = ~clk_sys;

  l4c_top dut (.CLK_SYS(clk_sys), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
               .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
               .PREADY(pready), .PSLVERR(pslverr));
  l4c_host host (.clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
                 .pslverr(pslverr), .hang(hang));

  function automatic logic [15:0] crc_step(input logic [15:0] v, input logic [7:0] b);
    logic [15:0] x;
    x = v ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      x = x[15] ? ((x << 1) ^ `L4C_POLY_DEFAULT) : (x << 1);
    return x;
  endfunction : crc_step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [9:0] idx, output logic [31:0] v);
    logic err;
    host.xfer(1'b0, idx, 2'b00, 32'h0, v, err);
  endtask : rd

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, 2'b00, {24'h0, d}, r, e);
  endtask : wr

  task automatic load(input logic [15:0] v);
    wr(`L4C_IDX_CRC_LOWER, v[15:8]);
    wr(`L4C_IDX_CRC_UPPER, v[7:0]);
  endtask : load

  task automatic expect_crc(input logic [15:0] v);
    rd(`L4C_IDX_CRC_UPPER, r);
    check("upper", r, {24'h0, v[7:0]});
    rd(`L4C_IDX_CRC_LOWER, r);
    check("lower", r, {24'h0, v[15:8]});
  endtask : expect_crc

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  always @(posedge hang)
  begin
    fails++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    expect_crc(16'h0000);
    rd(`L4C_IDX_RESULT, r);
    check("result after reset", r, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      load(row_init[i]);
      check("load accepted", e, 0);
      host.put(row_byte[i], GAP);
      expect_crc(row_crc[i]);
      rd(`L4C_IDX_RESULT, r);
      check("result", r, {31'h0, |row_crc[i]});
    end
    // Clear ignores the written data
    load(16'hbeef);
    expect_crc(16'hbeef);
    wr(`L4C_IDX_CLEAR, 8'hff);
    expect_crc(16'h0000);
    // Group followed by its own check value leaves zero
    wr(`L4C_IDX_CLEAR, 8'h00);
    host.put(8'h5a, GAP);
    host.put(8'hc3, GAP);
    c = crc_step(crc_step(16'h0000, 8'h5a), 8'hc3);
    host.put(c[15:8], GAP);
    host.put(c[7:0], GAP);
    rd(`L4C_IDX_RESULT, r);
    check("good group", r, 32'h0);
    // Short group inside a long one
    wr(`L4C_IDX_CLEAR, 8'h00);
    host.put(8'h11, GAP);
    rd(`L4C_IDX_CRC_UPPER, r);
    s[7:0] = r[7:0];
    rd(`L4C_IDX_CRC_LOWER, r);
    s[15:8] = r[7:0];
    wr(`L4C_IDX_CLEAR, 8'h00);
    host.put(8'h22, GAP);
    expect_crc(crc_step(16'h0000, 8'h22));
    load(s);
    host.put(8'h33, GAP);
    expect_crc(crc_step(crc_step(16'h0000, 8'h11), 8'h33));
    // Refused accesses, and a data read that returns zero
    wr(10'h3ff, 8'h00);
    check("unmapped", e, 1);
    wr(`L4C_IDX_RESULT, 8'h01);
    check("result write", e, 1);
    rd(`L4C_IDX_DATA, r);
    check("data read", r, 32'h0);
    host.xfer(1'b1, `L4C_IDX_CRC_UPPER, 2'b01, 32'h0, r, e);
    check("misaligned", e, 1);
    // Back to back bytes fill the buffer; the engine stalls the bus
    wr(`L4C_IDX_CLEAR, 8'h00);
    c = 16'h0000;
    for (int i = 1; i < 5; i++)
    begin
      host.put(i[7:0], 0);
      c = crc_step(c, i[7:0]);
    end
    wr(`L4C_IDX_CLEAR, 8'h00);
    check("clear while busy", e, 1);
    repeat (GAP) @(posedge clk_sys);
    check("stalled", host.stalls > 0, 1);
    expect_crc(c);
    // Reset while a byte shifts leaves nothing behind
    load(16'ha5c3);
    host.put(8'h5a, 2);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    expect_crc(16'h0000);
    rd(`L4C_IDX_RESULT, r);
    check("result after mid reset", r, 32'h0);
    close_out();
  end
endmodule : layer4_crc_engine_tb
